/* File: verilog/hs_gate_pkg.sv */
// Constants shared by the high-side gate permit block.
// Assumes a 100 MHz system clock and a 1.0 MHz reference clock.
package hs_gate_pkg;
  // ****************************************************************
  // Channels and clock
  // ****************************************************************
  localparam int NUM_CH = 7;
  localparam int CLK_PERIOD_NS = 10;
  localparam int REF_CLK_KHZ = 1000;
  // Reference period in system cycles
  localparam int REF_PERIOD_CYC = 1000000 / (REF_CLK_KHZ * CLK_PERIOD_NS);
  // Accepted window around the nominal period, in percent
  localparam int REF_TOL_PCT = 25;
  localparam logic [7:0] REF_MIN_CYC =
    8'(REF_PERIOD_CYC - (REF_PERIOD_CYC * REF_TOL_PCT) / 100);
  localparam logic [7:0] REF_MAX_CYC =
    8'(REF_PERIOD_CYC + (REF_PERIOD_CYC * REF_TOL_PCT) / 100);
  // Good periods needed before leaving the backup clock
  localparam logic [2:0] REF_GOOD_PERIODS = 3'h4;
  // ****************************************************************
  // Boost monitor
  // ****************************************************************
  // Threshold step in units of 0.1 mV
  localparam logic [19:0] BOOST_STEP = 20'h0_0C35;
  localparam logic [19:0] UV_STEP = 20'h0_0187;
  localparam logic [7:0] BOOST_CODE_MIN = 8'h08;
  localparam logic [7:0] BOOST_CODE_MAX = 8'hE1;
  localparam logic [7:0] BOOST_CODE_REC = 8'hD0;
  // Consecutive equal comparator samples to accept a change
  localparam logic [2:0] FILTER_LEN = 3'h4;
  // ****************************************************************
  // Edge strength codes, slew in V/us times ten
  // ****************************************************************
  localparam logic [1:0] SLEW_300 = 2'h0;
  localparam logic [1:0] SLEW_50 = 2'h1;
  localparam logic [1:0] SLEW_25 = 2'h2;
  localparam logic [1:0] SLEW_12P5 = 2'h3;
  localparam logic [1:0] SLEW_RESET = 2'h0;
  // Reset values of control bits
  localparam logic PLL_MOD_RESET = 1'b1;
  localparam logic CLK_KILL_RESET = 1'b0;
endpackage : hs_gate_pkg

/* File: verilog/qual_if.sv */
// Interface between the permit top and the per-channel qualifier.
// Assumes both ends sit in the system clock domain.
`timescale 1ns/100ps
interface qual_if;
  logic [6:0] request;
  logic [6:0] command;
  logic permit;
  logic supply_low;
  logic boost_kill;
  logic clock_kill;
  logic [1:0] override;
  modport src (output request, permit, supply_low, boost_kill,
               output clock_kill, override, input command);
  modport qual (input request, permit, supply_low, boost_kill,
                input clock_kill, override, output command);
endinterface : qual_if

/* File: verilog/gate_qualify.sv */
// Combinational gate command qualifier for all seven channels.
// Assumes qualifier levels are already synchronous to the clock.
`timescale 1ns/100ps
module gate_qualify
  import hs_gate_pkg::*;
(
  qual_if.qual q
);
  // Channels 5 and 7 own an override bit
  function automatic logic ovr_of(input int ch, input logic [1:0] ovr);
    if (ch == 4) begin
      return ovr[0];
    end
    if (ch == 6) begin
      return ovr[1];
    end
    return 1'b0;
  endfunction : ovr_of

  logic kill_all;

  // Qualifiers common to every channel
  assign kill_all = q.supply_low
                  | q.boost_kill
                  | q.clock_kill;

  // Per-channel combination, evaluated every cycle
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      assign q.command[ch] = q.request[ch]
        & (q.permit | ovr_of(ch, q.override))
        & ~kill_all;
    end
  endgenerate
endmodule : gate_qualify

/* File: verilog/boost_monitor.sv */
// Boost comparator filter, threshold set point and undervoltage flag.
// Assumes the comparator result is synchronous to the clock.
`timescale 1ns/100ps
module boost_monitor
  import hs_gate_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] code,
  input wire logic div_range_sel,
  input wire logic uv_kill_en,
  input wire logic cmp_above,
  output logic [19:0] thresh,
  output logic div_quarter,
  output logic above,
  output logic supply_low
);
  logic [2:0] agree;
  logic filt;

  // One filter for both modes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      agree <= 3'h0;
      filt <= 1'b1;
    end else if (cmp_above == filt) begin
      agree <= 3'h0;
    end else if (agree == FILTER_LEN - 3'h1) begin
      agree <= 3'h0;
      filt <= cmp_above;
    end else begin
      agree <= agree + 3'h1;
    end
  end

  // Threshold, divider and flag outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thresh <= 20'h0_0000;
      div_quarter <= 1'b0;
      above <= 1'b1;
      supply_low <= 1'b0;
    end else begin
      thresh <= div_range_sel ? 20'(code) * UV_STEP
                              : 20'(code) * BOOST_STEP;
      div_quarter <= div_range_sel;
      above <= filt;
      supply_low <= uv_kill_en & ~filt;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_thresh_boost: assert property (!div_range_sel |=>
    thresh == 20'($past(code)) * BOOST_STEP)
    else $error("boost threshold wrong");
  a_thresh_uv: assert property (div_range_sel |=>
    thresh == 20'($past(code)) * UV_STEP)
    else $error("uv threshold wrong");
  a_uv_flag_set: assert property (uv_kill_en && !filt |=>
    supply_low) else $error("uv flag not set");
  a_filter_hold: assert property (cmp_above == filt |=>
    $stable(filt)) else $error("filter moved without change");
endmodule : boost_monitor

/* File: verilog/hs_gate_permit.sv */
// Top of the high-side gate permit block: qualifies seven gate commands,
// holds edge strengths, boost monitor set point, clock source choice,
// frequency modulation and charge pump gating.
// Assumes pin inputs other than ext_clock_in, arst_n_in and chip_reset_n_in are synchronous to clock_in.
`timescale 1ns/100ps
module hs_gate_permit
  import hs_gate_pkg::*;
(
  // Clock and resets
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic power_on_reset_n_in,
  input wire logic chip_reset_n_in,
  // Safety qualifiers
  input wire logic driver_global_permit_pin_in,
  input wire logic predrv_supply_low_in,
  input wire logic logic_supply_low_in,
  input wire logic pll_locked_in,
  input wire logic clock_loss_kill_in,
  // Channel requests and overrides (bit 0 channel 5, bit 1 channel 7)
  input wire logic [6:0] hs_request_in,
  input wire logic [1:0] override_in,
  // Edge strength codes, two bits per channel
  input wire logic [13:0] rise_code_in,
  input wire logic [13:0] fall_code_in,
  // Boost monitor
  input wire logic [7:0] boost_code_in,
  input wire logic div_range_sel_in,
  input wire logic uv_kill_en_in,
  input wire logic boost_cmp_in,
  // Clock subsystem
  input wire logic ext_clock_in,
  input wire logic pll_mod_disable_in,
  // Gate commands and pin drive
  output logic [6:0] gate_cmd_out,
  output logic [6:0] gate_pull_up_out,
  output logic [6:0] gate_pull_down_out,
  // Active edge strengths
  output logic [13:0] rise_str_out,
  output logic [13:0] fall_str_out,
  // Boost monitor results
  output logic [19:0] boost_thresh_out,
  output logic div_quarter_out,
  output logic boost_above_out,
  output logic boost_supply_low_out,
  // Clock subsystem and charge pump
  output logic backup_clock_sel_out,
  output logic pll_mod_en_out,
  output logic charge_pump_run_out
);
  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta;
  logic rst_n;
  logic gate_rst_n;

  // Two-stage release of the board reset
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Chip reset clears gate flops without waiting for a clock
  assign gate_rst_n = rst_n & chip_reset_n_in;

  // ****************************************************************
  // Control bits
  // ****************************************************************
  logic clk_kill_en;

  // Clock-loss kill bit, cleared by reset
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      clk_kill_en <= CLK_KILL_RESET;
    end else begin
      clk_kill_en <= clock_loss_kill_in;
    end
  end

  // Modulation on out of reset, software may turn it off
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pll_mod_en_out <= PLL_MOD_RESET;
    end else begin
      pll_mod_en_out <= ~pll_mod_disable_in;
    end
  end

  // Charge pump held while power-on reset is low
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      charge_pump_run_out <= 1'b0;
    end else begin
      charge_pump_run_out <= power_on_reset_n_in;
    end
  end

  // ****************************************************************
  // Reference clock monitor
  // ****************************************************************
  logic ref_meta;
  logic ref_sync;
  logic ref_last;
  logic ref_rise;
  logic [7:0] ref_cnt;
  logic [2:0] good_cnt;
  logic ref_late;
  logic ref_early;

  // Two-stage sampler of the reference pin
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      ref_last <= 1'b0;
    end else begin
      ref_meta <= ext_clock_in;
      ref_sync <= ref_meta;
      ref_last <= ref_sync;
    end
  end

  // Edge and period checks against the 1.0 MHz nominal
  assign ref_rise = ref_sync & ~ref_last;
  assign ref_late = ref_cnt >= REF_MAX_CYC;
  assign ref_early = ref_rise & (ref_cnt < REF_MIN_CYC);

  // Cycles since the last reference edge, saturating
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt <= 8'h00;
    end else if (ref_rise) begin
      ref_cnt <= 8'h00;
    end else if (!ref_late) begin
      ref_cnt <= ref_cnt + 8'h01;
    end
  end

  // Switch to backup on a bad period, return after good ones
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      backup_clock_sel_out <= 1'b1;
      good_cnt <= 3'h0;
    end else if (ref_late || ref_early) begin
      backup_clock_sel_out <= 1'b1;
      good_cnt <= 3'h0;
    end else if (ref_rise && backup_clock_sel_out) begin
      if (good_cnt == REF_GOOD_PERIODS - 3'h1) begin
        backup_clock_sel_out <= 1'b0;
        good_cnt <= 3'h0;
      end else begin
        good_cnt <= good_cnt + 3'h1;
      end
    end
  end

  // ****************************************************************
  // Boost monitor
  // ****************************************************************
  boost_monitor u_boost (
    .clk (clock_in),
    .rst_n (rst_n),
    .code (boost_code_in),
    .div_range_sel (div_range_sel_in),
    .uv_kill_en (uv_kill_en_in),
    .cmp_above (boost_cmp_in),
    .thresh (boost_thresh_out),
    .div_quarter (div_quarter_out),
    .above (boost_above_out),
    .supply_low (boost_supply_low_out)
  );

  // ****************************************************************
  // Gate command qualification
  // ****************************************************************
  qual_if qbus ();
  logic [6:0] next_gate;

  // Qualifier levels into the per-channel combiner
  assign qbus.request = hs_request_in;
  assign qbus.permit = driver_global_permit_pin_in;
  assign qbus.override = override_in;
  assign qbus.supply_low = predrv_supply_low_in | logic_supply_low_in;
  assign qbus.boost_kill = boost_supply_low_out & uv_kill_en_in;
  assign qbus.clock_kill = clk_kill_en & ~pll_locked_in;
  assign next_gate = qbus.command;

  gate_qualify u_qual (
    .q (qbus.qual)
  );

  // Gate command and pin drive, one update per cycle
  always_ff @(posedge clock_in or negedge gate_rst_n) begin
    if (!gate_rst_n) begin
      gate_cmd_out <= 7'h00;
      gate_pull_up_out <= 7'h00;
      gate_pull_down_out <= 7'h7F;
    end else begin
      gate_cmd_out <= next_gate;
      gate_pull_up_out <= next_gate;
      gate_pull_down_out <= ~next_gate;
    end
  end

  // ****************************************************************
  // Edge strength per channel
  // ****************************************************************
  logic [13:0] rise_prev;
  logic [13:0] fall_prev;

  // Last seen codes, to spot a change
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      rise_prev <= {NUM_CH{SLEW_RESET}};
      fall_prev <= {NUM_CH{SLEW_RESET}};
    end else begin
      rise_prev <= rise_code_in;
      fall_prev <= fall_code_in;
    end
  end

  // A rising change rewrites both edges to keep equal slew
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_str
      always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
          rise_str_out[2*ch +: 2] <= SLEW_RESET;
          fall_str_out[2*ch +: 2] <= SLEW_RESET;
        end else if (rise_code_in[2*ch +: 2] != rise_prev[2*ch +: 2]) begin
          rise_str_out[2*ch +: 2] <= rise_code_in[2*ch +: 2];
          fall_str_out[2*ch +: 2] <= rise_code_in[2*ch +: 2];
        end else if (fall_code_in[2*ch +: 2] != fall_prev[2*ch +: 2]) begin
          fall_str_out[2*ch +: 2] <= fall_code_in[2*ch +: 2];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge clock_in); endclocking
  default disable iff (!gate_rst_n);

  // Permit and the channel 5 and 7 overrides

  a_permit_off: assert property (!driver_global_permit_pin_in |=>
    (gate_cmd_out & 7'h2F) == 7'h00)
    else $error("gate on without permit");
  a_override_pass: assert property (!driver_global_permit_pin_in
    && override_in[0] && hs_request_in[4] && !qbus.supply_low
    && !qbus.boost_kill && !qbus.clock_kill |=> gate_cmd_out[4])
    else $error("override channel blocked");
  a_override_ch7: assert property (!driver_global_permit_pin_in
    && override_in[1] && hs_request_in[6] && !qbus.supply_low
    && !qbus.boost_kill && !qbus.clock_kill |=> gate_cmd_out[6])
    else $error("channel 7 override blocked");

  // Kills force every gate off
  a_supply_kill: assert property (qbus.supply_low |=>
    gate_cmd_out == 7'h00) else $error("gate on in supply low");
  a_boost_kill: assert property (boost_supply_low_out && uv_kill_en_in
    |=> gate_cmd_out == 7'h00) else $error("gate on in boost low");
  a_clock_kill: assert property (clk_kill_en && !pll_locked_in |=>
    gate_cmd_out == 7'h00) else $error("gate on with pll unlocked");

  // Requests pass when nothing blocks them
  a_gate_pass: assert property (driver_global_permit_pin_in
    && !qbus.supply_low && !qbus.boost_kill && !qbus.clock_kill
    |=> gate_cmd_out == $past(hs_request_in))
    else $error("gate does not follow request");
  a_request_low: assert property (1'b1 |=>
    (gate_cmd_out & ~$past(hs_request_in)) == 7'h00)
    else $error("gate on without request");
  a_pull_exclusive: assert property (
    gate_pull_up_out == gate_cmd_out && gate_pull_down_out == ~gate_cmd_out)
    else $error("pin drive disagrees with command");
  a_chip_reset: assert property (disable iff (!rst_n)
    !chip_reset_n_in |-> gate_cmd_out == 7'h00)
    else $error("gate on in chip reset");

  // Edge strengths
  a_rise_tracks: assert property (
    rise_code_in[1:0] != rise_prev[1:0]
    |=> fall_str_out[1:0] == rise_str_out[1:0])
    else $error("falling strength not matched");
  a_rise_takes: assert property (
    rise_code_in[1:0] != rise_prev[1:0]
    |=> rise_str_out[1:0] == $past(rise_code_in[1:0]))
    else $error("rising strength not taken");
  a_fall_takes: assert property (
    rise_code_in[13:12] == rise_prev[13:12]
    && fall_code_in[13:12] != fall_prev[13:12]
    |=> fall_str_out[13:12] == $past(fall_code_in[13:12]))
    else $error("falling strength not taken");

  // Charge pump, modulation and clock source
  a_pump_stopped: assert property (!power_on_reset_n_in |=>
    !charge_pump_run_out) else $error("charge pump runs in reset");
  a_backup_switch: assert property (ref_late |=>
    backup_clock_sel_out) else $error("no backup on lost clock");
  a_mod_release: assert property (!pll_mod_disable_in [*2] |->
    pll_mod_en_out) else $error("modulation not enabled");
  a_mod_off: assert property (pll_mod_disable_in |=>
    !pll_mod_en_out) else $error("modulation not disabled");
  a_pump_run: assert property (power_on_reset_n_in |=>
    charge_pump_run_out) else $error("charge pump idle out of reset");
  a_early_switch: assert property (ref_early |=>
    backup_clock_sel_out) else $error("no backup on short period");
  a_backup_return: assert property (ref_rise && backup_clock_sel_out
    && good_cnt == REF_GOOD_PERIODS - 3'h1 && !ref_late && !ref_early
    |=> !backup_clock_sel_out) else $error("backup not left");
  a_ref_restart: assert property (ref_rise |=>
    ref_cnt == 8'h00) else $error("period count not restarted");
endmodule : hs_gate_permit

/* File: dv/hs_far_side.sv */
// Far side model: reference clock source and external gate levels.
// Assumes the bench starts and stops the reference clock by a level.
`timescale 1ns/100ps
module hs_far_side (
  // Control from the bench
  input wire logic ref_run_in,
  // Gate drive from the block
  input wire logic [6:0] pull_up_in,
  input wire logic [6:0] pull_down_in,
  // Reference clock and gate pin levels
  output logic ref_clock_out,
  output logic [6:0] gate_level_out
);
  // ******************************************************************
  // Reference clock
  // ******************************************************************
  // 1.0 MHz reference; stands low while stopped
  initial ref_clock_out = 1'b0;
  always #500 ref_clock_out = ref_run_in ? ~ref_clock_out : 1'b0;
  // ******************************************************************
  // Gate pins
  // ******************************************************************
  // Bootstrap when pulled up, else source via pull-down
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      gate_level_out[i] = (pull_up_in[i] & ~pull_down_in[i]);
    end
  end
endmodule : hs_far_side

/* File: dv/tb_top.sv */
// Self-checking bench for the high-side gate permit block.
// Assumes the far side model drives the reference clock.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  fail_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top
  import hs_gate_pkg::*;
;
  // ******************************************************************
  // Signals
  // ******************************************************************
  logic clock, arst_n, por_n, chip_rst_n, permit, plow, llow, locked;
  logic ckill, divsel, ukill, cmp, moddis, ref_run, bflag, ext_clk;
  logic [6:0] req, gate_cmd, pull_up, pull_down, gate_level;
  logic [1:0] ovr;
  logic [13:0] rise, fall, rise_q, fall_q, fexp, rise_str, fall_str;
  logic [7:0] code;
  logic [19:0] thresh;
  logic div_q, above, bsl, backup, mod_en, pump;
  logic [31:0] rnd;
  int fail_count, tests_run;
  // Design and far side
  hs_gate_permit uut (.clock_in(clock), .arst_n_in(arst_n),
    .power_on_reset_n_in(por_n), .chip_reset_n_in(chip_rst_n),
    .driver_global_permit_pin_in(permit), .predrv_supply_low_in(plow),
    .logic_supply_low_in(llow), .pll_locked_in(locked),
    .clock_loss_kill_in(ckill), .hs_request_in(req), .override_in(ovr),
    .rise_code_in(rise), .fall_code_in(fall), .boost_code_in(code),
    .div_range_sel_in(divsel), .uv_kill_en_in(ukill),
    .boost_cmp_in(cmp), .ext_clock_in(ext_clk),
    .pll_mod_disable_in(moddis), .gate_cmd_out(gate_cmd),
    .gate_pull_up_out(pull_up), .gate_pull_down_out(pull_down),
    .rise_str_out(rise_str), .fall_str_out(fall_str),
    .boost_thresh_out(thresh), .div_quarter_out(div_q),
    .boost_above_out(above), .boost_supply_low_out(bsl),
    .backup_clock_sel_out(backup), .pll_mod_en_out(mod_en),
    .charge_pump_run_out(pump));
  hs_far_side far (.ref_run_in(ref_run), .pull_up_in(pull_up),
    .pull_down_in(pull_down), .ref_clock_out(ext_clk),
    .gate_level_out(gate_level));
  // ******************************************************************
  // Helpers
  // ******************************************************************
  // Clock, 100 MHz
  always #5 clock = ~clock;
  // Advance n edges, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // Shift register step, 32 shifts per call
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 32; i++) begin
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    end
    return s;
  endfunction : lfsr
  // Reference gate command from the current qualifiers
  function automatic logic [6:0] gate_exp();
    logic [6:0] p;
    p = {7{permit}};
    p[4] = p[4] | ovr[0];
    p[6] = p[6] | ovr[1];
    if (plow | llow | (ckill & ~locked) | (ukill & bflag)) begin
      p = 7'h00;
    end
    return p & req;
  endfunction : gate_exp
  // Track the falling strength each channel should show
  task automatic track_strength();
    for (int i = 0; i < 7; i++) begin
      if (rise[2*i+:2] != rise_q[2*i+:2]) begin
        fexp[2*i+:2] = rise[2*i+:2];
      end else if (fall[2*i+:2] != fall_q[2*i+:2]) begin
        fexp[2*i+:2] = fall[2*i+:2];
      end
    end
    rise_q = rise;
    fall_q = fall;
  endtask : track_strength
  // Compare settled gate, pin, strength, threshold, divider, modulation and pump outputs with the model
  task automatic check_all();
    logic [19:0] th;
    th = 20'(code) * (divsel ? UV_STEP : BOOST_STEP);
    `CHK("gate", gate_exp(), gate_cmd)
    `CHK("pull_up", gate_exp(), pull_up)
    `CHK("pull_down", ~gate_exp(), pull_down)
    `CHK("gate_pin", gate_exp(), gate_level)
    `CHK("rise_str", rise, rise_str)
    `CHK("fall_str", fexp, fall_str)
    `CHK("thresh", th, thresh)
    `CHK("div", divsel, div_q)
    `CHK("mod_en", ~moddis, mod_en)
    `CHK("pump", por_n, pump)
  endtask : check_all
  // Random vector, held three cycles, then checked
  task automatic rand_vec();
    logic [31:0] a, b;
    a = lfsr(rnd);
    b = lfsr(a);
    rnd = b;
    req = a[6:0];
    ovr = a[8:7];
    permit = a[9] | a[10];
    plow = (a[13:11] == 3'h0);
    llow = (a[16:14] == 3'h0);
    locked = a[17] | a[18];
    ckill = a[19];
    ukill = a[20];
    divsel = a[21];
    moddis = a[22];
    por_n = a[23] | a[24];
    if (a[25]) rise = b[13:0];
    if (a[26]) fall = b[27:14];
    // Set point kept within 08h..D0h
    code = 8'h08 + 8'(b[31:24] % 8'hC9);
    track_strength();
    tick(3);
    check_all();
  endtask : rand_vec
  // Verdict and end of run
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  // ******************************************************************
  // Main sequence
  // ******************************************************************
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    conclude();
  end
  // Scenarios
  initial begin
    {clock, arst_n, permit, plow, llow, ckill, divsel, ukill} = '0;
    {moddis, bflag, ovr, req, rise, fall, rise_q, fall_q, fexp} = '0;
    {por_n, chip_rst_n, locked, cmp, ref_run} = 5'h1F;
    code = 8'h08;
    rnd = 32'h0001_4FEF;
    fail_count = 0;
    tests_run = 0;
    tick(6);
    arst_n = 1'b1;
    tick(3);
    check_all();
    `CHK("backup_rst", 1'b1, backup)
    for (int n = 0; n < 250; n++) begin
      rand_vec();
    end
    // One cycle response to qualifiers
    {plow, llow, ckill, ukill, ovr} = '0;
    locked = 1'b1;
    {permit, req} = 8'hFF;
    tick(1);
    `CHK("gate_lat", 7'h7F, gate_cmd)
    permit = 1'b0;
    ovr = 2'h3;
    tick(1);
    `CHK("gate_ovr", 7'h50, gate_cmd)
    permit = 1'b1;
    tick(2);
    // Chip reset clears the gates at once and holds them across an edge
    chip_rst_n = 1'b0;
    #2;
    `CHK("crst_cmd", 7'h00, gate_cmd)
    `CHK("crst_pd", 7'h7F, pull_down)
    tick(1);
    `CHK("crst_hold", 7'h00, gate_cmd)
    `CHK("crst_pin", 7'h00, gate_level)
    chip_rst_n = 1'b1;
    tick(1);
    check_all();
    // Short comparator glitch is filtered out
    ukill = 1'b1;
    cmp = 1'b0;
    tick(3);
    cmp = 1'b1;
    tick(4);
    `CHK("glitch", 1'b1, above)
    cmp = 1'b0;
    tick(8);
    bflag = 1'b1;
    `CHK("above", 1'b0, above)
    `CHK("uv_flag", 1'b1, bsl)
    check_all();
    // Kill disabled: flag drops and gates return
    ukill = 1'b0;
    tick(3);
    `CHK("uv_off", 1'b0, bsl)
    check_all();
    cmp = 1'b1;
    ukill = 1'b1;
    bflag = 1'b0;
    tick(8);
    `CHK("above_up", 1'b1, above)
    check_all();
    // Reference clock loss and return
    tick(400);
    `CHK("ref_good", 1'b0, backup)
    ref_run = 1'b0;
    tick(400);
    `CHK("ref_lost", 1'b1, backup)
    ref_run = 1'b1;
    tick(800);
    `CHK("ref_back", 1'b0, backup)
    // Board reset in mid-run: reset levels at once, inputs after release
    arst_n = 1'b0;
    #2;
    `CHK("rst_gate", 7'h00, gate_cmd)
    `CHK("rst_pd", 7'h7F, pull_down)
    `CHK("rst_rise", 14'h0000, rise_str)
    `CHK("rst_fall", 14'h0000, fall_str)
    `CHK("rst_thresh", 20'h0_0000, thresh)
    `CHK("rst_backup", 1'b1, backup)
    `CHK("rst_mod", 1'b1, mod_en)
    `CHK("rst_pump", 1'b0, pump)
    tick(1);
    arst_n = 1'b1;
    {rise_q, fall_q, fexp} = '0;
    track_strength();
    tick(3);
    check_all();
    `CHK("rst_back", 1'b1, backup)
    conclude();
  end
endmodule : tb_top
